// ### inc/rcfs_pkg.sv
// Function
// - configuration bank contents are shifted out serially to feed a chained device.
// - burst switches with hold high choose which peak detectors gate; with hold low, switch 1 chooses when to discharge.
// - burst switches also enable internal-signal output, track-follow and seek modes.
// - field select high takes comparator threshold from burst threshold input.
// - field select high routes gain control to burst gain capacitor.
// - with burst equalizer enable set, field select picks data or burst code.
// - optical strap grounded selects optical mode, left open selects magnetic.
// - hold high freezes the detector gain control level.
// - hold high in read mode makes synchronizer coast; otherwise no effect.
// - pump gain code combines pump gain input and pump ratio bit.
package rcfs_pkg;
	localparam int CFG_W = 16;
	localparam int CFG_WORDS = 4;
	localparam int IDX_W = 2;
	localparam int EQ_W = 3;
	localparam int AXI_AW = 8;
	// byte addresses of the register map
	localparam logic [AXI_AW-1:0] OFS_BANK00 = 8'h00;
	localparam logic [AXI_AW-1:0] OFS_BANK01 = 8'h04;
	localparam logic [AXI_AW-1:0] OFS_BANK10 = 8'h08;
	localparam logic [AXI_AW-1:0] OFS_BANK11 = 8'h0c;
	localparam logic [AXI_AW-1:0] OFS_CHAIN = 8'h10;
	localparam logic [AXI_AW-1:0] OFS_STATUS = 8'h14;
	localparam logic [IDX_W-1:0] IDX_BANK00 = 2'h0;
	localparam logic [IDX_W-1:0] IDX_BANK10 = 2'h2;
	localparam logic [IDX_W-1:0] IDX_BANK11 = 2'h3;
	// field positions inside the banks
	localparam int POS_BURST_EQ_EN = 12;
	localparam int POS_DATA_EQ = 9;
	localparam int POS_BURST_EQ = 10;
	localparam int POS_PUMP_RATIO = 12;
	localparam int POS_CHAIN_GO = 0;
	// reset values of the banks
	localparam logic [CFG_W-1:0] RST_BANK = 16'h0000;
	// timing
	localparam int CLK_PERIOD_PS = 5000;
	localparam int CHAIN_BIT_NS = 20;
	localparam int CHAIN_DIV = (CHAIN_BIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		CH_IDLE = 3'h1,
		CH_LOAD = 3'h2,
		CH_SHIFT = 3'h4
	} rcfs_chain_type;
endpackage

// ### inc/rcfs_cfg_if.sv
`timescale 1ns/100ps
interface rcfs_cfg_if;
	import rcfs_pkg::*;
	logic wr_en;
	logic [IDX_W-1:0] wr_idx;
	logic [CFG_W-1:0] wr_data;
	logic [1:0] wr_strb;
	logic [IDX_W-1:0] rd_idx;
	logic [CFG_W-1:0] rd_data;
	logic [CFG_W-1:0] words [CFG_WORDS];
	modport store (input wr_en, input wr_idx, input wr_data, input wr_strb, input rd_idx,
		output rd_data, output words);
	modport user (output wr_en, output wr_idx, output wr_data, output wr_strb, output rd_idx,
		input rd_data, input words);
endinterface

// ### verilog/rcfs_cfg_store.sv
`timescale 1ns/100ps
module rcfs_cfg_store (
	input wire logic clock,
	input wire logic rst_n,
	rcfs_cfg_if.store cfg
);
	import rcfs_pkg::*;
	logic [CFG_W-1:0] mem_q [CFG_WORDS];
	logic [CFG_W-1:0] rd_q;

	function automatic logic [CFG_W-1:0] merge(input logic [CFG_W-1:0] old,
		input logic [CFG_W-1:0] nw, input logic [1:0] strb);
		merge = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
	endfunction

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			for (int i = 0; i < CFG_WORDS; i++) begin
				mem_q[i] <= RST_BANK;
			end
		end else if (cfg.wr_en) begin
			mem_q[cfg.wr_idx] <= merge(mem_q[cfg.wr_idx], cfg.wr_data, cfg.wr_strb);
		end
	end

	// registered read port, one cycle behind rd_idx
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rd_q <= RST_BANK;
		end else begin
			rd_q <= mem_q[cfg.rd_idx];
		end
	end

	assign cfg.rd_data = rd_q;
	assign cfg.words = mem_q;
endmodule // rcfs_cfg_store

// ### verilog/rcfs_field_select.sv
`timescale 1ns/100ps
module rcfs_field_select #(
	parameter int CHAIN_DIV_P = rcfs_pkg::CHAIN_DIV
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [rcfs_pkg::AXI_AW-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [rcfs_pkg::AXI_AW-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	input wire logic burst_switch_1,
	input wire logic burst_switch_2,
	input wire logic burst_switch_3,
	input wire logic burst_switch_4,
	input wire logic agc_hold_in,
	input wire logic read_mode_in,
	input wire logic field_select_in,
	input wire logic optical_strap_in,
	input wire logic pump_gain_in,
	output logic threshold_from_burst,
	output logic gain_from_burst_cap,
	output logic [rcfs_pkg::EQ_W-1:0] equalizer_code,
	output logic optical_mode,
	output logic agc_freeze,
	output logic sync_coast,
	output logic [1:0] pump_gain_code,
	output logic [3:0] detector_gate,
	output logic burst_discharge,
	output logic internal_out_mode,
	output logic track_follow_mode,
	output logic seek_mode,
	output logic cfg_chain_out,
	output logic cfg_chain_busy
);
	import rcfs_pkg::*;
	localparam int CHAIN_BITS = CFG_W * CFG_WORDS;

	rcfs_cfg_if cfg ();
	rcfs_cfg_store u_store (
		.clock(clock),
		.rst_n(rst_n),
		.cfg(cfg)
	);

	function automatic logic [AXI_AW-1:0] word_addr(input logic [AXI_AW-1:0] a);
		word_addr = {a[AXI_AW-1:2], 2'h0};
	endfunction

	function automatic logic is_bank(input logic [AXI_AW-1:0] a);
		is_bank = word_addr(a) <= OFS_BANK11;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// axi4-lite write side
	logic aw_have_q, w_have_q, bvalid_q;
	logic [AXI_AW-1:0] aw_addr_q;
	logic [CFG_W-1:0] w_data_q;
	logic [1:0] w_strb_q;
	logic do_write, chain_go, wr_ok;
	logic [1:0] bresp_q;

	assign do_write = aw_have_q && w_have_q && !bvalid_q;
	assign wr_ok = is_bank(aw_addr_q) || word_addr(aw_addr_q) == OFS_CHAIN;
	assign chain_go = do_write && word_addr(aw_addr_q) == OFS_CHAIN && w_strb_q[0]
		&& w_data_q[POS_CHAIN_GO];

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			aw_have_q <= 1'b0;
			aw_addr_q <= '0;
		end else if (s_axi_awvalid && !aw_have_q) begin
			aw_have_q <= 1'b1;
			aw_addr_q <= s_axi_awaddr;
		end else if (do_write) begin
			aw_have_q <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			w_have_q <= 1'b0;
			w_data_q <= '0;
			w_strb_q <= '0;
		end else if (s_axi_wvalid && !w_have_q) begin
			w_have_q <= 1'b1;
			w_data_q <= s_axi_wdata[CFG_W-1:0];
			w_strb_q <= s_axi_wstrb[1:0];
		end else if (do_write) begin
			w_have_q <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else if (do_write) begin
			bvalid_q <= 1'b1;
			bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	assign s_axi_awready = !aw_have_q;
	assign s_axi_wready = !w_have_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign cfg.wr_en = do_write && is_bank(aw_addr_q);
	assign cfg.wr_idx = aw_addr_q[IDX_W+1:2];
	assign cfg.wr_data = w_data_q;
	assign cfg.wr_strb = w_strb_q;

	////////////////////////////////////////////////////////////////////////////////
	// axi4-lite read side: one cycle to fetch from the store, then rvalid
	logic rd_pend_q, rvalid_q;
	logic [AXI_AW-1:0] ar_addr_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic [31:0] status_word;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rd_pend_q <= 1'b0;
			ar_addr_q <= '0;
		end else if (s_axi_arvalid && !rd_pend_q && !rvalid_q) begin
			rd_pend_q <= 1'b1;
			ar_addr_q <= s_axi_araddr;
		end else begin
			rd_pend_q <= 1'b0;
		end
	end

	assign cfg.rd_idx = s_axi_araddr[IDX_W+1:2]; // store word fetched on the take edge

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= RESP_OKAY;
		end else if (rd_pend_q) begin
			rvalid_q <= 1'b1;
			rresp_q <= RESP_OKAY;
			if (is_bank(ar_addr_q)) begin
				rdata_q <= {16'h0000, cfg.rd_data};
			end else if (word_addr(ar_addr_q) == OFS_STATUS) begin
				rdata_q <= status_word;
			end else if (word_addr(ar_addr_q) == OFS_CHAIN) begin
				rdata_q <= '0;
			end else begin
				rdata_q <= '0;
				rresp_q <= RESP_SLVERR;
			end
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	assign s_axi_arready = !rd_pend_q && !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	////////////////////////////////////////////////////////////////////////////////
	// field steering
	logic burst_eq_en;
	logic [EQ_W-1:0] data_eq, burst_eq;
	logic [3:0] sw;

	assign burst_eq_en = cfg.words[IDX_BANK00][POS_BURST_EQ_EN];
	assign data_eq = cfg.words[IDX_BANK00][POS_DATA_EQ +: EQ_W];
	assign burst_eq = cfg.words[IDX_BANK11][POS_BURST_EQ +: EQ_W];
	assign sw = {burst_switch_4, burst_switch_3, burst_switch_2, burst_switch_1};

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			threshold_from_burst <= 1'b0;
			gain_from_burst_cap <= 1'b0;
			equalizer_code <= '0;
		end else begin
			threshold_from_burst <= field_select_in;
			gain_from_burst_cap <= field_select_in;
			// enable clear pins the data code whatever the field is
			equalizer_code <= (burst_eq_en && field_select_in) ? burst_eq : data_eq;
		end
	end

	// strap is sampled after reset release, never under reset itself
	logic strap_taken_q;
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			strap_taken_q <= 1'b0;
			optical_mode <= 1'b0;
		end else if (!strap_taken_q) begin
			strap_taken_q <= 1'b1;
			optical_mode <= !optical_strap_in;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			agc_freeze <= 1'b0;
			sync_coast <= 1'b0;
			pump_gain_code <= '0;
		end else begin
			agc_freeze <= agc_hold_in;
			sync_coast <= agc_hold_in && read_mode_in;
			pump_gain_code <= {pump_gain_in, cfg.words[IDX_BANK10][POS_PUMP_RATIO]};
		end
	end

	// hold high: switches pick gating detectors; hold low: switches pick modes
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			detector_gate <= '0;
			burst_discharge <= 1'b0;
			internal_out_mode <= 1'b0;
			track_follow_mode <= 1'b0;
			seek_mode <= 1'b0;
		end else begin
			detector_gate <= agc_hold_in ? sw : 4'h0;
			burst_discharge <= !agc_hold_in && sw[0];
			internal_out_mode <= !agc_hold_in && sw[1];
			track_follow_mode <= !agc_hold_in && sw[2];
			seek_mode <= !agc_hold_in && sw[3];
		end
	end

	assign status_word = {14'h0000, seek_mode, track_follow_mode, internal_out_mode,
		burst_discharge, cfg_chain_busy, detector_gate, pump_gain_code, equalizer_code,
		optical_mode, read_mode_in, agc_hold_in, field_select_in};

	////////////////////////////////////////////////////////////////////////////////
	// chain output: all banks, bank 3 msb first, one bit per divider pulse
	rcfs_chain_type ch_q;
	logic [CHAIN_BITS-1:0] sh_q;
	logic [7:0] bit_cnt_q;
	logic [15:0] div_q;
	logic tick;
	logic go_seen_q;

	assign tick = div_q == 16'(CHAIN_DIV_P - 1);

	always_ff @(posedge clock) begin
		if (!rst_n || ch_q != CH_SHIFT || tick) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + 16'h0001;
		end
	end

	// a request during a shift is kept and served afterwards
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			go_seen_q <= 1'b0;
		end else if (chain_go || cfg.wr_en) begin
			go_seen_q <= 1'b1;
		end else if (ch_q == CH_LOAD) begin
			go_seen_q <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ch_q <= CH_IDLE;
			sh_q <= '0;
			bit_cnt_q <= '0;
			cfg_chain_out <= 1'b0;
			cfg_chain_busy <= 1'b0;
		end else begin
			case (ch_q)
				CH_IDLE: begin
					cfg_chain_busy <= 1'b0;
					if (go_seen_q) begin
						ch_q <= CH_LOAD;
					end
				end
				CH_LOAD: begin
					sh_q <= {cfg.words[3], cfg.words[2], cfg.words[1], cfg.words[0]};
					bit_cnt_q <= 8'(CHAIN_BITS);
					cfg_chain_busy <= 1'b1;
					ch_q <= CH_SHIFT;
				end
				CH_SHIFT: begin
					if (tick) begin
						cfg_chain_out <= sh_q[CHAIN_BITS-1];
						sh_q <= {sh_q[CHAIN_BITS-2:0], 1'b0};
						bit_cnt_q <= bit_cnt_q - 8'h01;
						if (bit_cnt_q == 8'h01) begin
							ch_q <= CH_IDLE;
						end
					end
				end
				default: begin
					ch_q <= CH_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks
	a_thresh_follows: assert property (@(posedge clock) disable iff (!rst_n)
		##1 threshold_from_burst == $past(field_select_in))
		else $error("threshold select does not follow field select");
	a_gain_cap_follows: assert property (@(posedge clock) disable iff (!rst_n)
		##1 gain_from_burst_cap == $past(field_select_in))
		else $error("gain capacitor select does not follow field select");
	a_eq_burst_pick: assert property (@(posedge clock) disable iff (!rst_n)
		burst_eq_en && field_select_in |=> equalizer_code == $past(burst_eq))
		else $error("burst equalizer code not applied");
	a_eq_data_default: assert property (@(posedge clock) disable iff (!rst_n)
		!burst_eq_en |=> equalizer_code == $past(data_eq))
		else $error("data equalizer code not applied with enable clear");
	a_coast_read_only: assert property (@(posedge clock) disable iff (!rst_n)
		!read_mode_in |=> !sync_coast)
		else $error("synchronizer coasts outside read mode");
	a_hold_freeze: assert property (@(posedge clock) disable iff (!rst_n)
		agc_hold_in |=> agc_freeze)
		else $error("gain not frozen while hold high");
	a_gate_needs_hold: assert property (@(posedge clock) disable iff (!rst_n)
		!agc_hold_in |=> detector_gate == 4'h0 && burst_discharge == $past(sw[0]))
		else $error("detector gating without hold");
	a_modes_off_hold: assert property (@(posedge clock) disable iff (!rst_n)
		agc_hold_in |=> !seek_mode && !track_follow_mode && !internal_out_mode)
		else $error("switch modes active while hold high");
	a_pump_code: assert property (@(posedge clock) disable iff (!rst_n)
		##1 pump_gain_code[1] == $past(pump_gain_in))
		else $error("pump gain code does not follow pump gain input");
	a_chain_starts: assert property (@(posedge clock) disable iff (!rst_n)
		ch_q == CH_IDLE && go_seen_q |-> ##2 cfg_chain_busy)
		else $error("chain shift did not start");
endmodule // rcfs_field_select

// ### tb/rcfs_ctrl_model.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// controller and servo timing side: levels on the select pins
module rcfs_ctrl_model (
	input wire logic [8:0] plan,
	output logic [3:0] switches,
	output logic hold,
	output logic read_mode,
	output logic field_sel,
	output logic strap,
	output logic pump_gain
);
	// open strap floats to its pull-up, grounded reads low
	assign strap = plan[1] ? 1'b1 : 1'b0;
	assign {switches, hold, read_mode, field_sel} = plan[8:2];
	assign pump_gain = plan[0];
endmodule // rcfs_ctrl_model

// ### tb/tb.sv
`timescale 1ns/100ps
module tb;
	import rcfs_pkg::*;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, pgc;
	logic [8:0] plan = 9'h002;
	logic [3:0] sw, gate;
	logic hold, rdm, fld, strap, pump, thr, gcap, opt, frz, coast, dis, intm, trk, sk, cout, busy;
	logic [2:0] eq;
	int error_cnt = 0;
	int tests_run = 0;
	initial forever #2.5 clock = ~clock;
	rcfs_ctrl_model ctrl (.plan(plan), .switches(sw), .hold(hold), .read_mode(rdm),
		.field_sel(fld), .strap(strap), .pump_gain(pump));
	rcfs_field_select #(.CHAIN_DIV_P(4)) DUT (.clock(clock), .rst_n(rst_n),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
		.s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'h3), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .burst_switch_1(sw[0]), .burst_switch_2(sw[1]),
		.burst_switch_3(sw[2]), .burst_switch_4(sw[3]), .agc_hold_in(hold),
		.read_mode_in(rdm), .field_select_in(fld), .optical_strap_in(strap),
		.pump_gain_in(pump), .threshold_from_burst(thr), .gain_from_burst_cap(gcap),
		.equalizer_code(eq), .optical_mode(opt), .agc_freeze(frz), .sync_coast(coast),
		.pump_gain_code(pgc), .detector_gate(gate), .burst_discharge(dis),
		.internal_out_mode(intm), .track_follow_mode(trk), .seek_mode(sk),
		.cfg_chain_out(cout), .cfg_chain_busy(busy));
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string m);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, m, seen, exp);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// ready is comb, so look at it settled mid-cycle and act on the edge
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ra, rw, rb;
		@(posedge clock);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		rb = 1'b0;
		while (!rb) begin
			@(negedge clock);
			ra = awready;
			rw = wready;
			rb = bvalid;
			@(posedge clock);
			if (ra) awvalid <= 1'b0;
			if (rw) wvalid <= 1'b0;
			if (rb) r = bresp;
		end
		bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ra, rv;
		@(posedge clock);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		rv = 1'b0;
		while (!rv) begin
			@(negedge clock);
			ra = arready;
			rv = rvalid;
			@(posedge clock);
			if (ra) arvalid <= 1'b0;
			if (rv) d = rdata;
			if (rv) r = rresp;
		end
		rready <= 1'b0;
	endtask
	task automatic pins(input logic [8:0] p);
		@(posedge clock);
		plan <= p;
		repeat (2) @(posedge clock);
		@(negedge clock);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_steer();
		for (int i = 0; i < 4; i++) begin
			// strap is taken only after reset, so it stays open here
			pins({6'h0, i[0], 1'b1, i[1]});
			check(thr, i[0], "threshold source");
			check(gcap, i[0], "gain capacitor");
			check(opt, 1'b0, "magnetic mode with open strap");
			check(pgc, {i[1], 1'b0}, "pump gain code with ratio clear");
		end
		$display("t_steer done");
	endtask
	task automatic t_strap();
		@(posedge clock);
		plan <= 9'h000;
		rst_n <= 1'b0;
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		repeat (2) @(posedge clock);
		@(negedge clock);
		check(opt, 1'b1, "grounded strap gives optical mode");
		pins(9'h002);
		check(opt, 1'b1, "strap level kept until next reset");
		@(posedge clock);
		rst_n <= 1'b0;
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		repeat (2) @(posedge clock);
		@(negedge clock);
		check(opt, 1'b0, "open strap gives magnetic mode");
		$display("t_strap done");
	endtask
	task automatic t_hold();
		logic [3:0] s;
		for (int i = 0; i < 8; i++) begin
			s = i[0] ? 4'ha : 4'h5;
			pins({s, i[1], i[2], 3'h2});
			check(frz, i[1], "gain freeze");
			check(coast, i[1] & i[2], "coast only in read");
			check(gate, i[1] ? s : 4'h0, "detector gating");
			check({sk, trk, intm, dis}, i[1] ? 4'h0 : s, "switch modes");
		end
		$display("t_hold done");
	endtask
	task automatic t_eq();
		logic [1:0] r;
		axi_wr(OFS_BANK11, 32'h0000_0c00, r);
		axi_wr(OFS_BANK00, 32'h0000_1a00, r);
		pins(9'h002);
		check(eq, 3'h5, "data code");
		pins(9'h006);
		check(eq, 3'h3, "burst code");
		axi_wr(OFS_BANK00, 32'h0000_0a00, r);
		pins(9'h006);
		check(eq, 3'h5, "enable clear keeps data code");
		$display("t_eq done");
	endtask
	task automatic t_pump();
		logic [1:0] r;
		for (int i = 0; i < 4; i++) begin
			axi_wr(OFS_BANK10, {19'h0, i[1], 12'h0}, r);
			pins({8'h01, i[0]});
			check(pgc, {i[0], i[1]}, "pump gain code");
		end
		$display("t_pump done");
	endtask
	task automatic t_chain();
		logic [1:0] r;
		logic [31:0] d;
		logic [63:0] got;
		int n;
		axi_rd(8'h20, d, r);
		check(r, RESP_SLVERR, "unmapped read");
		check(d, 32'h0, "unmapped read data");
		axi_wr(OFS_STATUS, 32'h1, r);
		check(r, RESP_SLVERR, "status write");
		axi_wr(OFS_BANK01, 32'h0000_a5c3, r);
		check(r, RESP_OKAY, "bank write response");
		axi_rd(OFS_BANK01, d, r);
		check(r, RESP_OKAY, "bank read response");
		check(d, 32'h0000_a5c3, "bank readback");
		n = 0;
		// bank writes queue shifts of their own; let them drain first
		for (int t = 0; t < 2000 && n < 12; t++) begin
			@(negedge clock);
			n = busy ? 0 : n + 1;
		end
		axi_wr(OFS_CHAIN, 32'h1, r);
		n = 0;
		while (busy !== 1'b1 && n < 100) begin
			@(negedge clock);
			n++;
		end
		// first bit leaves one divider period after the shift starts
		repeat (4) @(negedge clock);
		for (int b = 63; b >= 0; b--) begin
			got[b] = cout;
			repeat (4) @(negedge clock);
		end
		check(got, 64'h0c00_1000_a5c3_0a00, "chained bank stream");
		repeat (4) @(negedge clock);
		check(busy, 1'b0, "chain idle after last bit");
		axi_rd(OFS_STATUS, d, r);
		check(r, RESP_OKAY, "status read response");
		check(d, 32'h0000_01d0, "status word");
		$display("t_chain done");
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		t_steer();
		t_strap();
		t_hold();
		t_eq();
		t_pump();
		t_chain();
		stop_test();
	end
	// whole run is under a thousand cycles
	initial begin
		#100000;
		error_cnt++;
		stop_test();
	end
endmodule // tb
